/* design/msw_pkg.sv */
// Purpose: Constants for the minute/second watchdog
// Assumes: 250 MHz system clock, 16-bit I/O address space
// Notes:   Register addresses are I/O port addresses
package msw_pkg;
   localparam logic [15:0] ADDR_UNIT_SELECT  = 16'h0665;
   localparam logic [15:0] ADDR_TIMEOUT_VAL  = 16'h0666;
   localparam logic [7:0]  UNIT_SELECT_RST   = 8'h00;
   localparam logic [7:0]  TIMEOUT_VAL_RST   = 8'h00;
   localparam logic [7:0]  TIMEOUT_STOP      = 8'h00;
   localparam int          UNIT_SEC_BIT      = 7;
   localparam int          CLK_HZ            = 250_000_000;
   localparam int          SEC_PER_MIN       = 60;
   localparam int          SEC_CYCLES_DFLT   = CLK_HZ;
   localparam int          CYC_W             = 28;
   localparam int          MIN_W             = 6;
   localparam logic [MIN_W-1:0] MIN_LAST     = 6'(SEC_PER_MIN - 1);
   localparam logic [7:0]  CNT_ONE           = 8'h01;
endpackage

/* design/msw_watchdog.sv */
// Purpose: Byte-programmable watchdog counting in minutes or seconds
// Assumes: Host I/O strobes are synchronous, one cycle per access
// Notes:   Timeout output is a one-cycle pulse; counter then stops
`timescale 1ns/1ps
`default_nettype none
module msw_watchdog #(
   parameter int SEC_CYCLES = msw_pkg::SEC_CYCLES_DFLT
) (
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic [15:0] i_io_addr,
   input  wire logic        i_io_wr,
   input  wire logic        i_io_rd,
   input  wire logic [7:0]  i_io_wdata,
   output logic      [7:0]  o_io_rdata,
   output logic             o_io_ack,
   output logic             o_running,
   output logic             o_timeout
);
   import msw_pkg::*;

   logic                rst_s1_r;
   logic                rst_s2_r;
   logic                rstn;
   logic [7:0]          unit_sel_r;
   logic [7:0]          tmo_val_r;
   logic [7:0]          count_r;
   logic                running_r;
   logic [CYC_W-1:0]    cyc_r;
   logic [MIN_W-1:0]    sec_r;
   logic                sec_tick;
   logic                unit_tick;
   logic                wr_unit;
   logic                wr_val;
   logic                load;

   localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(SEC_CYCLES - 1);

   // Reset release synchroniser
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rstn = rst_s2_r;

   // Address decode
   assign wr_unit = i_io_wr && (i_io_addr == ADDR_UNIT_SELECT);
   assign wr_val  = i_io_wr && (i_io_addr == ADDR_TIMEOUT_VAL);
   assign load    = wr_val && (i_io_wdata != TIMEOUT_STOP);

   // Unit select register
   always_ff @(posedge i_clk or negedge rstn) begin
      if (!rstn) begin
         unit_sel_r <= UNIT_SELECT_RST;
      end else if (wr_unit) begin
         unit_sel_r <= i_io_wdata;
      end
   end

   // Timeout value register
   always_ff @(posedge i_clk or negedge rstn) begin
      if (!rstn) begin
         tmo_val_r <= TIMEOUT_VAL_RST;
      end else if (wr_val) begin
         tmo_val_r <= i_io_wdata;
      end
   end

   // Read data and acknowledge
   always_ff @(posedge i_clk or negedge rstn) begin
      if (!rstn) begin
         o_io_rdata <= 8'h00;
         o_io_ack   <= 1'b0;
      end else begin
         o_io_ack <= (i_io_rd || i_io_wr) &&
                     ((i_io_addr == ADDR_UNIT_SELECT) ||
                      (i_io_addr == ADDR_TIMEOUT_VAL));
         if (i_io_rd && i_io_addr == ADDR_UNIT_SELECT) begin
            o_io_rdata <= unit_sel_r;
         end else if (i_io_rd && i_io_addr == ADDR_TIMEOUT_VAL) begin
            o_io_rdata <= tmo_val_r;
         end else begin
            o_io_rdata <= 8'h00;
         end
      end
   end

   // Prescaler, restarted on every load so the first unit is whole
   always_ff @(posedge i_clk or negedge rstn) begin
      if (!rstn) begin
         cyc_r <= '0;
         sec_r <= '0;
      end else if (load || !running_r) begin
         cyc_r <= '0;
         sec_r <= '0;
      end else if (sec_tick) begin
         cyc_r <= '0;
         sec_r <= (sec_r == MIN_LAST) ? '0 : sec_r + MIN_W'(1);
      end else begin
         cyc_r <= cyc_r + CYC_W'(1);
      end
   end
   assign sec_tick  = running_r && (cyc_r == CYC_LAST);
   assign unit_tick = sec_tick &&
                      (unit_sel_r[UNIT_SEC_BIT] || sec_r == MIN_LAST);

   // Countdown and timeout action
   always_ff @(posedge i_clk or negedge rstn) begin
      if (!rstn) begin
         count_r   <= 8'h00;
         running_r <= 1'b0;
         o_timeout <= 1'b0;
      end else begin
         o_timeout <= 1'b0;
         if (load) begin
            count_r   <= i_io_wdata;
            running_r <= 1'b1;
         end else if (wr_val) begin
            running_r <= 1'b0;
            count_r   <= TIMEOUT_STOP;
         end else if (unit_tick) begin
            count_r <= count_r - CNT_ONE;
            if (count_r == CNT_ONE) begin
               running_r <= 1'b0;
               o_timeout <= 1'b1;
            end
         end
      end
   end

   // Running flag mirror
   always_ff @(posedge i_clk or negedge rstn) begin
      if (!rstn) begin
         o_running <= 1'b0;
      end else begin
         o_running <= load || (running_r && !wr_val &&
                      !(unit_tick && count_r == CNT_ONE));
      end
   end

   // Stop write blocks any timeout next cycle
   a_stop_quiet: assert property (@(posedge i_clk)
      disable iff (!rstn)
      (wr_val && i_io_wdata == TIMEOUT_STOP) |=> !o_timeout && !running_r)
      else $error("timeout after stop write");
   // Load starts the counter with the written value
   a_load_start: assert property (@(posedge i_clk)
      disable iff (!rstn)
      load |=> running_r && count_r == $past(i_io_wdata))
      else $error("load did not start countdown");
   // Reload restarts the count
   a_reload_restart: assert property (@(posedge i_clk)
      disable iff (!rstn)
      (load && running_r) |=> count_r == $past(i_io_wdata))
      else $error("reload did not restart");
   // Timeout only from last unit
   a_timeout_cause: assert property (@(posedge i_clk)
      disable iff (!rstn)
      o_timeout |-> $past(unit_tick) && $past(count_r) == CNT_ONE)
      else $error("timeout without expiry");
   // Expiry fires timeout
   a_expiry_fires: assert property (@(posedge i_clk)
      disable iff (!rstn)
      (unit_tick && count_r == CNT_ONE && !wr_val) |=> o_timeout)
      else $error("expiry missed");
   // Timeout action is a single-cycle pulse
   a_timeout_pulse: assert property (@(posedge i_clk)
      disable iff (!rstn)
      o_timeout |=> !o_timeout)
      else $error("timeout pulse too long");
   // Seconds mode takes one off the count on every second tick
   a_second_unit: assert property (@(posedge i_clk)
      disable iff (!rstn)
      (sec_tick && unit_sel_r[UNIT_SEC_BIT] && !wr_val) |=>
         count_r == $past(count_r) - CNT_ONE)
      else $error("second unit not stepped");
   // Minutes mode holds the count until the last second of a minute
   a_minute_unit: assert property (@(posedge i_clk)
      disable iff (!rstn)
      (sec_tick && !unit_sel_r[UNIT_SEC_BIT] && sec_r != MIN_LAST &&
       !wr_val) |=> $stable(count_r))
      else $error("minute unit stepped early");
   // Counter moves by one per tick only
   a_count_step: assert property (@(posedge i_clk)
      disable iff (!rstn)
      (running_r && !wr_val && !unit_tick) |=> $stable(count_r))
      else $error("count moved without tick");
   // Unit register write visible on read
   a_unit_write: assert property (@(posedge i_clk)
      disable iff (!rstn)
      wr_unit |=> unit_sel_r == $past(i_io_wdata))
      else $error("unit register not written");
   // Prescaler never passes the last cycle of a second
   a_prescale_bound: assert property (@(posedge i_clk)
      disable iff (!rstn)
      !(cyc_r > CYC_LAST))
      else $error("prescaler overran");
   // A stopped counter holds zero, so nothing can expire
   a_stopped_zero: assert property (@(posedge i_clk)
      disable iff (!rstn)
      !running_r |-> count_r == TIMEOUT_STOP)
      else $error("stopped counter not zero");
   // Running output tracks the internal flag
   a_run_mirror: assert property (@(posedge i_clk)
      disable iff (!rstn)
      o_running == running_r)
      else $error("running output out of step");
   // Mapped access is acknowledged next cycle
   a_ack_mapped: assert property (@(posedge i_clk)
      disable iff (!rstn)
      ((i_io_rd || i_io_wr) && (i_io_addr == ADDR_UNIT_SELECT ||
       i_io_addr == ADDR_TIMEOUT_VAL)) |=> o_io_ack)
      else $error("mapped access not acknowledged");
   // No strobe, no acknowledge
   a_ack_idle: assert property (@(posedge i_clk)
      disable iff (!rstn)
      !(i_io_rd || i_io_wr) |=> !o_io_ack)
      else $error("acknowledge without access");
   // Timeout value register reads back what is stored
   a_read_value: assert property (@(posedge i_clk)
      disable iff (!rstn)
      (i_io_rd && i_io_addr == ADDR_TIMEOUT_VAL) |=>
         o_io_rdata == $past(tmo_val_r))
      else $error("timeout value read wrong");
   // Unit select register reads back what is stored
   a_read_unit: assert property (@(posedge i_clk)
      disable iff (!rstn)
      (i_io_rd && i_io_addr == ADDR_UNIT_SELECT) |=>
         o_io_rdata == $past(unit_sel_r))
      else $error("unit select read wrong");
endmodule
`default_nettype wire

/* verif/test_msw_watchdog.sv */
// Purpose: Self-checking bench for the minute/second watchdog
// Assumes: SEC_CYCLES shortened to 4 so minute counts stay short
// Notes:   Inputs change 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
module test_msw_watchdog;
   import msw_pkg::*;
   localparam int SC = 4;
   logic        i_clk = 1'b0;
   logic        i_rstn = 1'b0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wd = 8'h00;
   logic [7:0]  rdata;
   logic        ack;
   logic        run;
   logic        tmo;
   int          fails = 0;
   int          num_checks = 0;
   int          cyc = 0;
   msw_watchdog #(.SEC_CYCLES(SC)) u_msw_watchdog (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_io_addr(addr), .i_io_wr(wr),
      .i_io_rd(rd), .i_io_wdata(wd), .o_io_rdata(rdata), .o_io_ack(ack),
      .o_running(run), .o_timeout(tmo));
   // Clock and hang guard
   always #2 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         close_out();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One I/O access; answer is visible on return
   task automatic acc(input logic w, input logic [15:0] a,
                      input logic [7:0] d);
      @(posedge i_clk);
      #1 addr = a;
      wd = d;
      wr = w;
      rd = !w;
      @(posedge i_clk);
      #1 wr = 1'b0;
      rd = 1'b0;
   endtask
   // Counts edges from the load until the expiry pulse or the limit
   task automatic wait_tmo(input int lim, input int exp);
      int n;
      n = 0;
      while (n < lim && tmo !== 1'b1) begin
         @(posedge i_clk);
         #1 n++;
      end
      chk(16'(n), 16'(exp));
      if (tmo === 1'b1) chk({15'h0000, run}, 16'h0000);
   endtask
   task automatic t_reset();
      chk({15'h0000, run}, 16'h0000);
      acc(1'b0, ADDR_UNIT_SELECT, 8'h00);
      chk({8'h00, rdata}, {8'h00, UNIT_SELECT_RST});
      chk({15'h0000, ack}, 16'h0001);
      acc(1'b0, ADDR_TIMEOUT_VAL, 8'h00);
      chk({8'h00, rdata}, {8'h00, TIMEOUT_VAL_RST});
      acc(1'b0, 16'h0667, 8'h00);
      chk({7'h00, ack, rdata}, 16'h0000);
   endtask
   task automatic t_sec();
      acc(1'b1, ADDR_UNIT_SELECT, 8'h80);
      chk({15'h0000, ack}, 16'h0001);
      acc(1'b0, ADDR_UNIT_SELECT, 8'h00);
      chk({8'h00, rdata}, 16'h0080);
      acc(1'b1, ADDR_TIMEOUT_VAL, 8'h03);
      chk({15'h0000, run}, 16'h0001);
      wait_tmo(1100, 3 * SC);
      acc(1'b1, ADDR_TIMEOUT_VAL, 8'hFF);
      wait_tmo(1100, 255 * SC);
   endtask
   task automatic t_reload();
      acc(1'b1, ADDR_TIMEOUT_VAL, 8'h02);
      repeat (5) @(posedge i_clk);
      acc(1'b1, ADDR_TIMEOUT_VAL, 8'h02);
      wait_tmo(1100, 2 * SC);
   endtask
   task automatic t_stop();
      acc(1'b1, ADDR_TIMEOUT_VAL, 8'h02);
      acc(1'b1, ADDR_TIMEOUT_VAL, TIMEOUT_STOP);
      chk({15'h0000, run}, 16'h0000);
      wait_tmo(30, 30);
   endtask
   task automatic t_min();
      acc(1'b1, ADDR_UNIT_SELECT, 8'h00);
      acc(1'b1, ADDR_TIMEOUT_VAL, 8'h01);
      wait_tmo(1100, SEC_PER_MIN * SC);
   endtask
   task automatic close_out();
      $display("Checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge i_clk);
      #1 i_rstn = 1'b1;
      repeat (3) @(posedge i_clk);
      t_reset();
      t_sec();
      t_reload();
      t_stop();
      t_min();
      close_out();
   end
endmodule
`default_nettype wire
